// [btq_pkg.sv]
// Package of constants and types for the bus trace and event qualifier.
package btq_pkg;

  // Register byte offsets
  localparam logic [7:0] BTQ_CTRL_OFS = 8'h00;
  localparam logic [7:0] BTQ_STAT_OFS = 8'h04;
  localparam logic [7:0] BTQ_ADDR_A_LO_OFS = 8'h08;
  localparam logic [7:0] BTQ_ADDR_A_HI_OFS = 8'h0C;
  localparam logic [7:0] BTQ_ADDR_B_LO_OFS = 8'h10;
  localparam logic [7:0] BTQ_ADDR_B_HI_OFS = 8'h14;
  localparam logic [7:0] BTQ_DATA_A_OFS = 8'h18;
  localparam logic [7:0] BTQ_DATA_B_OFS = 8'h1C;
  localparam logic [7:0] BTQ_STATUS_A_OFS = 8'h20;
  localparam logic [7:0] BTQ_STATUS_B_OFS = 8'h24;
  localparam logic [7:0] BTQ_PROBE_OFS = 8'h28;
  localparam logic [7:0] BTQ_LIMIT_OFS = 8'h2C;
  localparam logic [7:0] BTQ_SELECT_OFS = 8'h30;
  localparam logic [7:0] BTQ_COUNT_OFS = 8'h34;
  localparam logic [7:0] BTQ_INDEX_OFS = 8'h38;
  localparam logic [7:0] BTQ_TR_ADDR_OFS = 8'h40;
  localparam logic [7:0] BTQ_TR_DATA_OFS = 8'h44;
  localparam logic [7:0] BTQ_TR_STAT_OFS = 8'h48;
  localparam logic [7:0] BTQ_TR_TIME_OFS = 8'h4C;

  // Control register fields
  localparam int BTQ_CTRL_MODE_LSB = 0;
  localparam int BTQ_CTRL_REC_BIT = 2;
  localparam int BTQ_CTRL_CLR_BIT = 3;
  // Status register fields
  localparam int BTQ_STAT_HALT_BIT = 2;
  localparam int BTQ_STAT_WRAP_BIT = 3;
  localparam int BTQ_STAT_PTR_LSB = 16;
  // Select register fields: bits 0..7 pick comparators, then action and range bits
  localparam int BTQ_SEL_ACT_BIT = 8;
  localparam int BTQ_SEL_RANGE_A_BIT = 9;
  localparam int BTQ_SEL_RANGE_B_BIT = 10;
  localparam int BTQ_NUM_CMP = 8;

  // Trace status bit positions
  localparam int BTQ_S_BYTE = 0;
  localparam int BTQ_S_READ = 1;
  localparam int BTQ_S_TARGET = 2;
  localparam int BTQ_S_FC_LSB = 4;
  localparam int BTQ_S_HIADDR_LSB = 7;
  localparam int BTQ_S_VIOL = 7;
  localparam int BTQ_S_FAULT = 8;
  localparam int BTQ_S_IRQ_LSB = 9;
  localparam int BTQ_S_BREAK = 12;
  localparam int BTQ_S_AUTO_VEC = 13;
  localparam int BTQ_S_PEND = 14;

  // Trace modes
  localparam logic [1:0] BTQ_MODE_0 = 2'h0;
  localparam logic [1:0] BTQ_MODE_1 = 2'h1;
  localparam logic [1:0] BTQ_MODE_2 = 2'h2;

  // Reset values and count saturation value
  localparam logic [1:0] BTQ_MODE_RST = 2'h0;
  localparam logic [15:0] BTQ_LIMIT_RST = 16'h0001;
  localparam logic [15:0] BTQ_COUNT_MAX = 16'hFFFF;

  // AXI responses
  localparam logic [1:0] BTQ_RESP_OKAY = 2'h0;
  localparam logic [1:0] BTQ_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    BTQ_IDLE = 2'b00,
    BTQ_REC = 2'b01,
    BTQ_HALT = 2'b11
  } btq_state_t;

  // One target bus cycle; done marks its completion
  typedef struct packed {
    logic done;
    logic [31:0] addr;
    logic [31:0] data;
    logic [2:0] func_code;
    logic target_access;
    logic read;
    logic byte_access;
    logic [2:0] irq_level_lines;
    logic irq_pending_line;
    logic auto_vector_line;
    logic bus_fault_line;
    logic access_violation;
  } btq_bus_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] data;
    logic [19:0] status;
    logic [23:0] timer;
    logic [15:0] probe_state;
  } btq_entry_t;

  // Masked comparator: set bits of dont_care are ignored
  typedef struct packed {
    logic [15:0] dont_care;
    logic [15:0] value;
  } btq_cmp_t;

endpackage : btq_pkg

// [btq_trace_mem.sv]
// Trace buffer memory with registered read data.
module btq_trace_mem #(
  parameter int WIDTH = 100,
  parameter int DEPTH = 256,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule : btq_trace_mem

// [btq_qualifier.sv]
// Trace capture, event comparators and AXI4-Lite register slave.
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
module btq_qualifier #(
  parameter int DEPTH = 256
) (
  input wire logic aclk,
  input wire logic aresetn,
  input btq_pkg::btq_bus_t bus_in,
  input wire logic [15:0] probe_in,
  output logic halt_action,
  output logic halted,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);
  import btq_pkg::*;

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || AW > 16) begin : g_depth_check
    $error("DEPTH must be a power of two from 2 to 65536");
  end

  typedef struct packed {
    btq_state_t state;
    logic [1:0] mode;
    logic rec_en;
    logic [1:0][23:0] addr_lo;
    logic [1:0][23:0] addr_hi;
    logic [1:0] range_en;
    btq_cmp_t [1:0] data_cmp;
    btq_cmp_t [1:0] stat_cmp;
    btq_cmp_t probe_cmp;
    logic [15:0] limit;
    logic [BTQ_NUM_CMP-1:0] select;
    logic act_en;
    logic [15:0] count;
    logic [23:0] timer;
    logic [AW-1:0] wr_ptr;
    logic wrapped;
    logic [AW-1:0] index;
    logic halt_pulse;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } btq_regs_t;

  btq_regs_t s_reg;
  btq_regs_t s_next;
  btq_entry_t cap_entry;
  btq_entry_t mem_entry;
  logic [$bits(btq_entry_t)-1:0] mem_rdata;
  logic mem_we;

  function automatic logic masked_eq(logic [15:0] val, btq_cmp_t c);
    masked_eq = ((val ^ c.value) & ~c.dont_care) == 16'h0000;
  endfunction : masked_eq

  function automatic logic addr_hit(logic [23:0] a, logic [23:0] lo, logic [23:0] hi,
                                    logic rng);
    if (rng) begin
      addr_hit = (a >= lo) && (a <= hi);
    end else begin
      addr_hit = (a == lo);
    end
  endfunction : addr_hit

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = r;
  endfunction : merge

  // Map one bus cycle onto the fixed trace fields for the given mode
  function automatic btq_entry_t build_entry(logic [1:0] md, btq_bus_t b, logic [15:0] pr,
                                             logic [23:0] tm);
    btq_entry_t e;
    e = '0;
    e.addr = b.addr[23:0];
    e.data = b.data[31:16];
    e.timer = tm;
    if (md == BTQ_MODE_1 || md == BTQ_MODE_2) begin
      e.probe_state = b.data[15:0];
    end else begin
      e.probe_state = pr;
    end
    e.status[BTQ_S_BYTE] = b.byte_access;
    e.status[BTQ_S_READ] = b.read;
    e.status[BTQ_S_TARGET] = b.target_access;
    e.status[BTQ_S_FC_LSB +: 3] = b.func_code;
    if (md == BTQ_MODE_2) begin
      e.status[BTQ_S_HIADDR_LSB +: 8] = b.addr[31:24];
    end else begin
      e.status[BTQ_S_VIOL] = b.access_violation;
      e.status[BTQ_S_FAULT] = b.bus_fault_line;
      e.status[BTQ_S_IRQ_LSB +: 3] = b.irq_level_lines;
      e.status[BTQ_S_AUTO_VEC] = b.auto_vector_line;
      e.status[BTQ_S_PEND] = b.irq_pending_line;
    end
    build_entry = e;
  endfunction : build_entry

  function automatic logic [31:0] rd_word(btq_regs_t st, logic [7:0] a, btq_entry_t me);
    logic [31:0] v;
    v = '0;
    unique case (a)
      BTQ_CTRL_OFS: begin
        v[BTQ_CTRL_MODE_LSB +: 2] = st.mode;
        v[BTQ_CTRL_REC_BIT] = st.rec_en;
      end
      BTQ_STAT_OFS: begin
        v[1:0] = st.state;
        v[BTQ_STAT_HALT_BIT] = (st.state == BTQ_HALT);
        v[BTQ_STAT_WRAP_BIT] = st.wrapped;
        v[BTQ_STAT_PTR_LSB +: AW] = st.wr_ptr;
      end
      BTQ_ADDR_A_LO_OFS: v[23:0] = st.addr_lo[0];
      BTQ_ADDR_A_HI_OFS: v[23:0] = st.addr_hi[0];
      BTQ_ADDR_B_LO_OFS: v[23:0] = st.addr_lo[1];
      BTQ_ADDR_B_HI_OFS: v[23:0] = st.addr_hi[1];
      BTQ_DATA_A_OFS: v = st.data_cmp[0];
      BTQ_DATA_B_OFS: v = st.data_cmp[1];
      BTQ_STATUS_A_OFS: v = st.stat_cmp[0];
      BTQ_STATUS_B_OFS: v = st.stat_cmp[1];
      BTQ_PROBE_OFS: v = st.probe_cmp;
      BTQ_LIMIT_OFS: v[15:0] = st.limit;
      BTQ_SELECT_OFS: begin
        v[BTQ_NUM_CMP-1:0] = st.select;
        v[BTQ_SEL_ACT_BIT] = st.act_en;
        v[BTQ_SEL_RANGE_A_BIT] = st.range_en[0];
        v[BTQ_SEL_RANGE_B_BIT] = st.range_en[1];
      end
      BTQ_COUNT_OFS: v[15:0] = st.count;
      BTQ_INDEX_OFS: v[AW-1:0] = st.index;
      BTQ_TR_ADDR_OFS: v[23:0] = me.addr;
      BTQ_TR_DATA_OFS: v = {me.probe_state, me.data};
      BTQ_TR_STAT_OFS: v[19:0] = me.status;
      BTQ_TR_TIME_OFS: v[23:0] = me.timer;
      default: v = '0;
    endcase
    rd_word = v;
  endfunction : rd_word

  function automatic logic is_mapped(logic [7:0] a);
    is_mapped = (a <= BTQ_INDEX_OFS || (a >= BTQ_TR_ADDR_OFS && a <= BTQ_TR_TIME_OFS))
                && a[1:0] == 2'b00;
  endfunction : is_mapped

  assign mem_entry = btq_entry_t'(mem_rdata);

  always_comb begin
    logic [BTQ_NUM_CMP-1:0] hit;
    logic [15:0] cnt_inc;
    logic fire;
    logic traced;
    logic [31:0] wv;
    s_next = s_reg;
    hit = '0;
    cnt_inc = '0;
    fire = 1'b0;
    traced = 1'b0;
    wv = '0;
    s_next.halt_pulse = 1'b0;
    s_next.timer = s_reg.timer + 24'h000001;

    // Capture uses the mode held now, so a new mode applies from the next cycle on
    cap_entry = build_entry(s_reg.mode, bus_in, probe_in, s_reg.timer);
    traced = bus_in.done && (s_reg.state == BTQ_REC);
    cnt_inc = (s_reg.count == BTQ_COUNT_MAX) ? s_reg.count : s_reg.count + 16'h0001;

    hit[0] = addr_hit(cap_entry.addr, s_reg.addr_lo[0], s_reg.addr_hi[0],
                      s_reg.range_en[0]);
    hit[1] = addr_hit(cap_entry.addr, s_reg.addr_lo[1], s_reg.addr_hi[1],
                      s_reg.range_en[1]);
    hit[2] = masked_eq(cap_entry.data, s_reg.data_cmp[0]);
    hit[3] = masked_eq(cap_entry.data, s_reg.data_cmp[1]);
    hit[4] = masked_eq(cap_entry.status[15:0], s_reg.stat_cmp[0]);
    hit[5] = masked_eq(cap_entry.status[15:0], s_reg.stat_cmp[1]);
    hit[6] = masked_eq(cap_entry.probe_state, s_reg.probe_cmp);
    hit[7] = (cnt_inc == s_reg.limit);

    // An empty selection never fires, so an unprogrammed monitor stays quiet
    fire = traced && s_reg.act_en && (s_reg.select != '0)
           && ((hit & s_reg.select) == s_reg.select);

    if (fire && s_reg.mode != BTQ_MODE_2) begin
      cap_entry.status[BTQ_S_BREAK] = 1'b1;
    end
    mem_we = traced;

    unique case (s_reg.state)
      BTQ_IDLE: begin
        if (s_reg.rec_en) begin
          s_next.state = BTQ_REC;
        end
      end
      BTQ_REC: begin
        if (traced) begin
          s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
          s_next.wrapped = s_reg.wrapped | (&s_reg.wr_ptr);
          s_next.count = cnt_inc;
        end
        if (fire) begin
          s_next.state = BTQ_HALT;
          s_next.halt_pulse = 1'b1;
        end else if (!s_reg.rec_en) begin
          s_next.state = BTQ_IDLE;
        end
      end
      BTQ_HALT: begin
      end
      default: s_next.state = BTQ_IDLE;
    endcase

    // Write channel: address and data taken in either order
    if (awvalid && awready) begin
      s_next.aw_got = 1'b1;
      s_next.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      s_next.w_got = 1'b1;
      s_next.w_data = wdata;
      s_next.w_strb = wstrb;
    end
    if (s_reg.aw_got && s_reg.w_got) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = is_mapped(s_reg.aw_addr) ? BTQ_RESP_OKAY : BTQ_RESP_SLVERR;
      wv = merge(rd_word(s_reg, s_reg.aw_addr, mem_entry), s_reg.w_data, s_reg.w_strb);
      unique case (s_reg.aw_addr)
        BTQ_CTRL_OFS: begin
          s_next.mode = wv[BTQ_CTRL_MODE_LSB +: 2];
          s_next.rec_en = wv[BTQ_CTRL_REC_BIT];
          if (wv[BTQ_CTRL_REC_BIT] && !s_reg.rec_en) begin
            s_next.count = '0;
          end
          if (wv[BTQ_CTRL_CLR_BIT] && s_reg.state == BTQ_HALT) begin
            s_next.state = BTQ_IDLE;
            s_next.count = '0;
          end
        end
        BTQ_ADDR_A_LO_OFS: s_next.addr_lo[0] = wv[23:0];
        BTQ_ADDR_A_HI_OFS: s_next.addr_hi[0] = wv[23:0];
        BTQ_ADDR_B_LO_OFS: s_next.addr_lo[1] = wv[23:0];
        BTQ_ADDR_B_HI_OFS: s_next.addr_hi[1] = wv[23:0];
        BTQ_DATA_A_OFS: s_next.data_cmp[0] = wv;
        BTQ_DATA_B_OFS: s_next.data_cmp[1] = wv;
        BTQ_STATUS_A_OFS: s_next.stat_cmp[0] = wv;
        BTQ_STATUS_B_OFS: s_next.stat_cmp[1] = wv;
        BTQ_PROBE_OFS: s_next.probe_cmp = wv;
        BTQ_LIMIT_OFS: begin
          if (wv[15:0] != 16'h0000) begin
            s_next.limit = wv[15:0];
          end
        end
        BTQ_SELECT_OFS: begin
          s_next.select = wv[BTQ_NUM_CMP-1:0];
          s_next.act_en = wv[BTQ_SEL_ACT_BIT];
          s_next.range_en[0] = wv[BTQ_SEL_RANGE_A_BIT];
          s_next.range_en[1] = wv[BTQ_SEL_RANGE_B_BIT];
        end
        BTQ_INDEX_OFS: s_next.index = wv[AW-1:0];
        default: begin
        end
      endcase
    end
    if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
    end

    // Read channel: answer one cycle after the address is taken
    if (arvalid && arready) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = rd_word(s_reg, araddr, mem_entry);
      s_next.rresp = is_mapped(araddr) ? BTQ_RESP_OKAY : BTQ_RESP_SLVERR;
    end else if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.state <= BTQ_IDLE;
      s_reg.mode <= BTQ_MODE_RST;
      s_reg.limit <= BTQ_LIMIT_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  btq_trace_mem #(
    .WIDTH($bits(btq_entry_t)),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(mem_we),
    .waddr(s_reg.wr_ptr),
    .wdata(cap_entry),
    .raddr(s_reg.index),
    .rdata(mem_rdata)
  );

  // Index register steers the buffer read, so trace words follow it by one cycle
  assign awready = !s_reg.aw_got && !s_reg.bvalid;
  assign wready = !s_reg.w_got && !s_reg.bvalid;
  assign arready = !s_reg.rvalid;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign rvalid = s_reg.rvalid;
  assign rdata = s_reg.rdata;
  assign rresp = s_reg.rresp;
  assign halt_action = s_reg.halt_pulse;
  assign halted = (s_reg.state == BTQ_HALT);
endmodule : btq_qualifier

// [btq_qualifier_chk.sv]
// Assertions on the trace qualifier ports.
module btq_qualifier_chk #(
  parameter int DEPTH = 256
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire btq_pkg::btq_bus_t bus_in,
  input wire logic halt_action,
  input wire logic halted,
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import btq_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_halt_one_cycle: assert property (halt_action |=> !halt_action)
    else $error("halt pulse too long");
  a_halt_from_done: assert property (halt_action |-> $past(bus_in.done))
    else $error("halt without a bus cycle");
  a_halt_enters: assert property (halt_action |-> halted && !$past(halted))
    else $error("halt pulse without entering halt");
  a_halt_no_refire: assert property ($past(halted) && halted |-> !halt_action)
    else $error("halt fired while halted");
  a_halt_leave_write: assert property ($fell(halted) && $past(aresetn) |-> bvalid)
    else $error("halt left without a register write");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_write_busy: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read not answered next cycle");
endmodule : btq_qualifier_chk

bind btq_qualifier btq_qualifier_chk #(.DEPTH(DEPTH)) u_btq_qualifier_chk (
  .aclk(aclk), .aresetn(aresetn), .bus_in(bus_in), .halt_action(halt_action),
  .halted(halted), .awready(awready), .wready(wready), .bvalid(bvalid), .bready(bready),
  .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
  .rdata(rdata)
);

// [btq_target_model.sv]
// Target bus model that issues completed bus cycles.
module btq_target_model (
  input wire logic aclk,
  output btq_pkg::btq_bus_t bus_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import btq_pkg::*;
  initial bus_in = '0;
  // Fields are scrambled after the cycle so stale values never match
  task automatic cycle(input btq_bus_t b);
    @(posedge aclk);
    bus_in <= b;
    @(posedge aclk);
    bus_in <= {1'b0, ~b[76:0]};
  endtask : cycle
endmodule : btq_target_model

// [tb_btq_qualifier.sv]
// Self-checking testbench for the trace qualifier.
module tb_btq_qualifier;
  timeunit 1ns;
  timeprecision 1ps;
  import btq_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic halt_action, halted, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, last, t1;
  logic [15:0] probe_in;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, lastr;
  btq_bus_t bus_in, b, c;
  int mismatches = 0;
  int checks = 0;
  int halts = 0;
  int wp = 0;
  int m, i;
  logic [31:0] addrs [6] = '{32'hFF, 32'h100, 32'h1FF, 32'h200, 32'h1FF, 32'h100};
  int ex [6] = '{0, 1, 1, 0, 0, 1};

  btq_qualifier #(.DEPTH(4)) u_btq_qualifier (
    .aclk(aclk), .aresetn(aresetn), .bus_in(bus_in), .probe_in(probe_in),
    .halt_action(halt_action), .halted(halted), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp)
  );
  btq_target_model u_btq_target_model (.aclk(aclk), .bus_in(bus_in));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (halt_action === 1'b1) halts <= halts + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] x, input string what);
    checks++;
    if (got !== x) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, x);
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic tmo;
    mismatches++;
    $display("wrong value at %0t: bus wait ran out", $time);
    final_report();
  endtask : tmo

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0,
      input logic [3:0] s = 4'hF);
    int n;
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1 && bready === 1'b1) break;
      if (bvalid === 1'b1) bready <= 1'b1;
    end
    bready <= 1'b0;
    if (n == 40) tmo();
    chk({30'h0, bresp}, {30'h0, e}, "bresp");
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1 && rready === 1'b1) break;
      if (rvalid === 1'b1) rready <= 1'b1;
    end
    rready <= 1'b0;
    if (n == 40) tmo();
    last = rdata;
    lastr = rresp;
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e = 2'h0);
    rd(a);
    chk(last, x, "rdata");
    chk({30'h0, lastr}, {30'h0, e}, "rresp");
  endtask : rd_chk

  function automatic btq_bus_t mk(input logic [31:0] a, input logic [31:0] d,
      input logic [2:0] fc, input logic [2:0] irq, input logic [6:0] f);
    return {1'b1, a, d, fc, f[6:4], irq, f[3:0]};
  endfunction : mk

  function automatic logic [31:0] est(input btq_bus_t x, input logic [1:0] md, input logic k);
    if (md == BTQ_MODE_2)
      return {17'h0, x.addr[31:24], x.func_code, 1'b0, x.target_access, x.read, x.byte_access};
    return {17'h0, x.irq_pending_line, x.auto_vector_line, k, x.irq_level_lines,
      x.bus_fault_line, x.access_violation, x.func_code, 1'b0, x.target_access, x.read,
      x.byte_access};
  endfunction : est

  task automatic go(input btq_bus_t x);
    u_btq_target_model.cycle(x);
    wp++;
  endtask : go

  task automatic hit(input btq_bus_t x, input int e);
    int h;
    h = halts;
    go(x);
    repeat (2) @(posedge aclk);
    chk(32'(halts - h), 32'(e), "halt pulses");
    chk({31'h0, halted}, 32'(e), "halted");
  endtask : hit

  task automatic entry(input btq_bus_t x, input logic [1:0] md, input logic k, input int s);
    wr(BTQ_INDEX_OFS, 32'(s % 4));
    rd_chk(BTQ_TR_ADDR_OFS, {8'h0, x.addr[23:0]});
    rd_chk(BTQ_TR_DATA_OFS,
      {(md == 1 || md == 2) ? x.data[15:0] : probe_in, x.data[31:16]});
    rd_chk(BTQ_TR_STAT_OFS, est(x, md, k));
    rd(BTQ_TR_TIME_OFS);
  endtask : entry

  task automatic trial(input logic [7:0] r, input logic [31:0] v, input logic [31:0] sel,
      input btq_bus_t x, input int e);
    wr(r, v);
    wr(BTQ_SELECT_OFS, sel);
    wr(BTQ_CTRL_OFS, 32'h8);
    wr(BTQ_CTRL_OFS, 32'h5);
    hit(x, e);
  endtask : trial

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    probe_in = 16'h5A3C;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(BTQ_CTRL_OFS, 32'h0);
    rd_chk(BTQ_LIMIT_OFS, 32'h1);
    wr(BTQ_LIMIT_OFS, 32'h0);
    rd_chk(BTQ_LIMIT_OFS, 32'h1);
    rd_chk(8'h3C, 32'h0, BTQ_RESP_SLVERR);
    wr(8'h3C, 32'h1, BTQ_RESP_SLVERR);
    wr(BTQ_LIMIT_OFS, 32'h0000AB05, BTQ_RESP_OKAY, 4'h1);
    rd_chk(BTQ_LIMIT_OFS, 32'h5);
    $display("test registers done");
    for (m = 0; m < 4; m++) begin
      wr(BTQ_CTRL_OFS, 32'h8);
      wr(BTQ_CTRL_OFS, 32'(m) | 32'h4);
      rd_chk(BTQ_CTRL_OFS, 32'(m) | 32'h4);
      b = mk(32'hA5123456 ^ 32'(m << 28), 32'h89ABCDEF, 3'h5, 3'h6, 7'h5A);
      c = mk(32'h5A0000F0, 32'h13572468, 3'h2, 3'h1, 7'h25);
      go(b);
      go(c);
      entry(b, 2'(m), 1'b0, wp - 2);
      t1 = last;
      entry(c, 2'(m), 1'b0, wp - 1);
      chk(last - t1, 32'h2, "timer step");
    end
    $display("test capture modes done");
    wr(BTQ_DATA_A_OFS, 32'h000F89A0);
    b = mk(32'h100, 32'h89ABCDEF, 3'h1, 3'h0, 7'h0);
    trial(BTQ_PROBE_OFS, 32'h0000CDEF, 32'h144,
      mk(32'h100, 32'h89ABCDEE, 3'h1, 3'h0, 7'h0), 0);
    hit(mk(32'h100, 32'h88ABCDEF, 3'h1, 3'h0, 7'h0), 0);
    hit(b, 1);
    entry(b, 2'h1, 1'b1, wp - 1);
    $display("test data match done");
    wr(BTQ_ADDR_A_LO_OFS, 32'h100);
    wr(BTQ_ADDR_A_HI_OFS, 32'h1FF);
    for (i = 0; i < 6; i++) begin
      trial(BTQ_SELECT_OFS, i < 4 ? 32'h301 : 32'h101, i < 4 ? 32'h301 : 32'h101,
        mk(addrs[i], 32'h0, 3'h0, 3'h0, 7'h0), ex[i]);
    end
    $display("test address match done");
    // One status category per status trial, except function code with read and byte together; then the B comparators
    trial(BTQ_STATUS_A_OFS, 32'hF1FF0A00, 32'h110, mk(0, 0, 3'h0, 3'h5, 7'h0), 1);
    trial(BTQ_STATUS_A_OFS, 32'hF1FF0A00, 32'h110, mk(0, 0, 3'h0, 3'h4, 7'h0), 0);
    trial(BTQ_STATUS_A_OFS, 32'hFF8C0033, 32'h110,
      mk(0, 0, 3'h3, 3'h0, 7'h30), 1);
    trial(BTQ_STATUS_A_OFS, 32'hFF8C0033, 32'h110, mk(0, 0, 3'h3, 3'h0, 7'h20), 0);
    trial(BTQ_STATUS_A_OFS, 32'hBFFF4000, 32'h110, mk(0, 0, 3'h0, 3'h0, 7'h08), 1);
    trial(BTQ_STATUS_A_OFS, 32'hDFFF2000, 32'h110, mk(0, 0, 3'h0, 3'h0, 7'h04), 1);
    trial(BTQ_STATUS_A_OFS, 32'hFEFF0100, 32'h110, mk(0, 0, 3'h0, 3'h0, 7'h02), 1);
    trial(BTQ_STATUS_A_OFS, 32'hFFFB0004, 32'h110, mk(0, 0, 3'h0, 3'h0, 7'h40), 1);
    trial(BTQ_ADDR_B_LO_OFS, 32'h777, 32'h102, mk(32'h777, 0, 3'h0, 3'h0, 7'h0), 1);
    trial(BTQ_DATA_B_OFS, 32'h1234, 32'h108, mk(0, 32'h12340000, 3'h0, 3'h0, 7'h0), 1);
    trial(BTQ_STATUS_B_OFS, 32'hFFFE0001, 32'h120, mk(0, 0, 3'h0, 3'h0, 7'h10), 1);
    $display("test status match done");
    trial(BTQ_LIMIT_OFS, 32'h3, 32'h180, b, 0);
    hit(b, 0);
    hit(b, 1);
    u_btq_target_model.cycle(b);
    rd_chk(BTQ_COUNT_OFS, 32'h3);
    rd_chk(BTQ_STAT_OFS, {14'h0, 2'(wp % 4), 16'h000F});
    $display("test count limit done");
    final_report();
  end
endmodule : tb_btq_qualifier
